// >>> pkg/jlm_defines.svh
// Offsets, field positions, reset values and counts of the lane mapper
`ifndef JLM_DEFINES_SVH
`define JLM_DEFINES_SVH
`define JLM_CTRL_OFFSET 8'h00
`define JLM_MODE_OFFSET 8'h04
`define JLM_STAT_OFFSET 8'h08
`define JLM_CTRL_LMODE_LSB 0
`define JLM_CTRL_TPAT_LSB 8
`define JLM_CTRL_PDA_BIT 16
`define JLM_CTRL_PDB_BIT 17
`define JLM_CTRL_XA_BIT 18
`define JLM_CTRL_XB_BIT 19
`define JLM_STAT_FLUSHED_BIT 16
`define JLM_STAT_PDPIN_BIT 17
`define JLM_LMODE_RESET 5'h04
`define JLM_TPAT_RESET 3'h0
`define JLM_OPMODE_RESET 8'h00
`define JLM_TPAT_NORMAL 3'h0
`define JLM_TPAT_PRBS7 3'h1
`define JLM_TPAT_PRBS15 3'h2
`define JLM_TPAT_PRBS23 3'h3
`define JLM_TPAT_RAMP 3'h4
`define JLM_TPAT_SHORT 3'h5
`define JLM_TPAT_D215 3'h6
`define JLM_D215_OCTET 8'hb5
`define JLM_FLUSH_CYCLES 16
`endif

// >>> pkg/jlm_pkg.sv
// Types shared by the lane mapper
package jlm_pkg;
   typedef logic [15:0][7:0] jlm_frame_t;
   typedef enum {
      JLM_PAT_NORMAL,
      JLM_PAT_PRBS7,
      JLM_PAT_PRBS15,
      JLM_PAT_PRBS23,
      JLM_PAT_RAMP,
      JLM_PAT_SHORT,
      JLM_PAT_D215
   } jlm_pattern_t;
   typedef struct packed {
      logic link_b_extra_lane_enable;
      logic link_a_extra_lane_enable;
      logic channel_b_power_down;
      logic channel_a_power_down;
      logic [2:0] test_pattern_select;
      logic [4:0] lane_mode_select;
   } jlm_ctrl_t;
endpackage

// >>> rtl/jlm_lane_mapper.sv
// Lane mapper, lane power control and test patterns with an AHB-Lite slave
//
// Overview of operation
// - Every tail-bit and unused position of an output octet is driven zero.
// - Each sample octet goes out with bit 7 first, bit 0 last.
// - Mode 5: even samples 0-6 on link A lanes 0-3, odd on B.
// - Mode 17: even samples 0-14 on link A lanes 0-7, odd on B.
// - Mode 6: channel A samples 0,1 on link A, channel B on link B.
// - Mode 7: channel sample k on that link's lane k, k 0 to 3.
// - Mode 18: channel sample k on that link's lane k, k 0 to 7.
// - Lowest-indexed lanes of each link are used, higher ones powered down.
// - Power-down pin high disables all lane output drivers.
// - Operating mode other than 0x00 or 0x01 powers down all serializers.
// - A channel power-down bit powers down that channel's lanes.
// - Lanes the lane mode leaves unused have serializers powered down.
// - After pin or operating-mode power-down, data is held off until the pipeline is flushed; a channel power-down bit does not restart the flush.
// - Extra-lane enables keep unused lanes on and toggling.
// - Pattern chosen by select field; lane power follows lane mode, not pattern.
// - PRBS octets bypass the 8b/10b encoder.
// - PRBS7 taps 6,7; PRBS15 taps 14,15; PRBS23 taps 18,23.
// - Each lane's PRBS generator starts from its own seed.
// - Ramp: after alignment every lane sends one counting octet, wrapping.
// - Short transport: lane k sends k, then 0xFF minus k, repeating.
// - D21.5 mode sends a continuous stream of D21.5 characters.
//
// The AHB-Lite register port and the register addresses were decided locally.
`include "jlm_defines.svh"

module jlm_lane_mapper (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Converter side, one frame per clock
   input wire jlm_pkg::jlm_frame_t sample_frame,
   input wire logic power_down_pin,
   // Link layer side
   input wire logic ila_done,
   output jlm_pkg::jlm_frame_t lane_octet,
   output logic [15:0] lane_enable,
   output logic encoder_bypass,
   output logic data_flushed
);

   // ********************************
   // Functions
   // ********************************
   function automatic logic [3:0] lanes_per_link(input logic [4:0] m);
      unique case (m)
         5'd4, 5'd6: lanes_per_link = 4'd2;
         5'd5, 5'd7: lanes_per_link = 4'd4;
         5'd17, 5'd18: lanes_per_link = 4'd8;
         default: lanes_per_link = 4'd0;
      endcase
   endfunction

   function automatic logic is_single(input logic [4:0] m);
      is_single = (m == 5'd4) || (m == 5'd5) || (m == 5'd17);
   endfunction

   function automatic jlm_pkg::jlm_pattern_t decode_pattern(
      input logic [2:0] c);
      unique case (c)
         `JLM_TPAT_PRBS7: decode_pattern = jlm_pkg::JLM_PAT_PRBS7;
         `JLM_TPAT_PRBS15: decode_pattern = jlm_pkg::JLM_PAT_PRBS15;
         `JLM_TPAT_PRBS23: decode_pattern = jlm_pkg::JLM_PAT_PRBS23;
         `JLM_TPAT_RAMP: decode_pattern = jlm_pkg::JLM_PAT_RAMP;
         `JLM_TPAT_SHORT: decode_pattern = jlm_pkg::JLM_PAT_SHORT;
         `JLM_TPAT_D215: decode_pattern = jlm_pkg::JLM_PAT_D215;
         default: decode_pattern = jlm_pkg::JLM_PAT_NORMAL;
      endcase
   endfunction

   // One PRBS bit from the history, bit 0 being the last bit sent
   // An all-zero window is kicked out, else a pattern switch could lock up
   function automatic logic prbs_bit(input logic [22:0] s,
                                     input jlm_pkg::jlm_pattern_t p);
      unique case (p)
         jlm_pkg::JLM_PAT_PRBS15:
            prbs_bit = s[13] ^ s[14] ^ (s[14:0] == 15'h0);
         jlm_pkg::JLM_PAT_PRBS23:
            prbs_bit = s[17] ^ s[22] ^ (s == 23'h0);
         default: prbs_bit = s[5] ^ s[6] ^ (s[6:0] == 7'h0);
      endcase
   endfunction

   // ********************************
   // Register file
   // ********************************
   jlm_pkg::jlm_ctrl_t ctrl_reg;
   logic [7:0] opmode_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] stat_word;
   logic [31:0] ctrl_word;
   logic addr_ok;
   logic pd_sync_reg;

   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[`JLM_CTRL_LMODE_LSB +: 5] = ctrl_reg.lane_mode_select;
      ctrl_word[`JLM_CTRL_TPAT_LSB +: 3] = ctrl_reg.test_pattern_select;
      ctrl_word[`JLM_CTRL_PDA_BIT] = ctrl_reg.channel_a_power_down;
      ctrl_word[`JLM_CTRL_PDB_BIT] = ctrl_reg.channel_b_power_down;
      ctrl_word[`JLM_CTRL_XA_BIT] = ctrl_reg.link_a_extra_lane_enable;
      ctrl_word[`JLM_CTRL_XB_BIT] = ctrl_reg.link_b_extra_lane_enable;
      stat_word = 32'h0;
      stat_word[15:0] = lane_enable;
      stat_word[`JLM_STAT_FLUSHED_BIT] = data_flushed;
      stat_word[`JLM_STAT_PDPIN_BIT] = pd_sync_reg;
   end

   // Write address is caught in the address phase, data taken one cycle on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg.lane_mode_select <= `JLM_LMODE_RESET;
         ctrl_reg.test_pattern_select <= `JLM_TPAT_RESET;
         ctrl_reg.channel_a_power_down <= 1'b0;
         ctrl_reg.channel_b_power_down <= 1'b0;
         ctrl_reg.link_a_extra_lane_enable <= 1'b0;
         ctrl_reg.link_b_extra_lane_enable <= 1'b0;
         opmode_reg <= `JLM_OPMODE_RESET;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == `JLM_CTRL_OFFSET) begin
            ctrl_reg.lane_mode_select <= hwdata[`JLM_CTRL_LMODE_LSB +: 5];
            ctrl_reg.test_pattern_select <= hwdata[`JLM_CTRL_TPAT_LSB +: 3];
            ctrl_reg.channel_a_power_down <= hwdata[`JLM_CTRL_PDA_BIT];
            ctrl_reg.channel_b_power_down <= hwdata[`JLM_CTRL_PDB_BIT];
            ctrl_reg.link_a_extra_lane_enable <= hwdata[`JLM_CTRL_XA_BIT];
            ctrl_reg.link_b_extra_lane_enable <= hwdata[`JLM_CTRL_XB_BIT];
         end
         if (wr_addr_reg == `JLM_MODE_OFFSET) begin
            opmode_reg <= hwdata[7:0];
         end
      end
   end

   // Zero wait states: read data is loaded at the address phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
               `JLM_CTRL_OFFSET: hrdata <= ctrl_word;
               `JLM_MODE_OFFSET: hrdata <= {24'h0, opmode_reg};
               `JLM_STAT_OFFSET: hrdata <= stat_word;
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end

   // ********************************
   // Power-down pin and lane power
   // ********************************
   logic pd_s1_reg;
   logic pd_s2_reg;
   logic pd_s3_reg;
   logic all_down;
   logic [3:0] nlanes;
   logic [15:0] used_lanes;
   logic [15:0] enable_next;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_s1_reg <= 1'b0;
         pd_s2_reg <= 1'b0;
         pd_s3_reg <= 1'b0;
         pd_sync_reg <= 1'b0;
      end else begin
         pd_s1_reg <= power_down_pin;
         pd_s2_reg <= pd_s1_reg;
         pd_s3_reg <= pd_s2_reg;
         if (pd_s2_reg == pd_s3_reg) begin
            pd_sync_reg <= pd_s3_reg;
         end
      end
   end

   assign all_down = pd_sync_reg
      || (opmode_reg != 8'h00 && opmode_reg != 8'h01);
   assign nlanes = lanes_per_link(ctrl_reg.lane_mode_select);

   // Lane power depends on the lane mode and the power and extra-lane controls, never on the pattern
   always_comb begin
      used_lanes = 16'h0;
      enable_next = 16'h0;
      for (int k = 0; k < 8; k++) begin
         used_lanes[k] = (4'(k) < nlanes);
         used_lanes[8 + k] = (4'(k) < nlanes);
         enable_next[k] = !all_down && !ctrl_reg.channel_a_power_down
            && (used_lanes[k]
               || ctrl_reg.link_a_extra_lane_enable);
         enable_next[8 + k] = !all_down && !ctrl_reg.channel_b_power_down
            && (used_lanes[8 + k]
               || ctrl_reg.link_b_extra_lane_enable);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_enable <= 16'h0;
      end else begin
         lane_enable <= enable_next;
      end
   end

   // ********************************
   // Pipeline flush after power-down
   // ********************************
   // Octets stay zero until stale pipeline content has drained out
   logic [7:0] flush_cnt_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flush_cnt_reg <= 8'h0;
         data_flushed <= 1'b0;
      end else if (all_down) begin
         flush_cnt_reg <= 8'h0;
         data_flushed <= 1'b0;
      end else if (flush_cnt_reg != 8'(`JLM_FLUSH_CYCLES)) begin
         flush_cnt_reg <= flush_cnt_reg + 8'h1;
         data_flushed <= 1'b0;
      end else begin
         data_flushed <= 1'b1;
      end
   end

   // ********************************
   // Test pattern sources
   // ********************************
   jlm_pkg::jlm_pattern_t pat;
   logic [15:0][22:0] prbs_reg;
   logic [15:0][22:0] prbs_next;
   logic [15:0][7:0] prbs_octet;
   logic [7:0] ramp_reg;
   logic frame_sel_reg;

   assign pat = decode_pattern(ctrl_reg.test_pattern_select);

   // Eight PRBS bits per lane per clock, first bit into bit 7
   always_comb begin
      logic [22:0] s;
      s = 23'h0;
      prbs_octet = '0;
      for (int l = 0; l < 16; l++) begin
         s = prbs_reg[l];
         for (int b = 7; b >= 0; b--) begin
            s = {s[21:0], prbs_bit(s, pat)};
            prbs_octet[l][b] = s[0];
         end
         prbs_next[l] = s;
      end
   end

   // A seed per lane so no two lanes run in phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int l = 0; l < 16; l++) begin
            prbs_reg[l] <= {18'h0, 5'(l + 1)};
         end
      end else begin
         prbs_reg <= prbs_next;
      end
   end

   // Ramp waits for alignment, then counts and wraps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_reg <= 8'h00;
      end else if (!ila_done) begin
         ramp_reg <= 8'h00;
      end else begin
         ramp_reg <= ramp_reg + 8'h01;
      end
   end

   // One frame per clock, so the two-frame pattern alternates each cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_sel_reg <= 1'b0;
      end else begin
         frame_sel_reg <= !frame_sel_reg;
      end
   end

   // ********************************
   // Lane mapping and output
   // ********************************
   jlm_pkg::jlm_frame_t octet_next;
   logic single;

   assign single = is_single(ctrl_reg.lane_mode_select);

   always_comb begin
      octet_next = '0;
      for (int l = 0; l < 16; l++) begin
         if (lane_enable[l] && data_flushed && !all_down) begin
            unique case (pat)
               jlm_pkg::JLM_PAT_PRBS7, jlm_pkg::JLM_PAT_PRBS15,
               jlm_pkg::JLM_PAT_PRBS23:
                  octet_next[l] = prbs_octet[l];
               jlm_pkg::JLM_PAT_RAMP:
                  octet_next[l] = ramp_reg;
               jlm_pkg::JLM_PAT_SHORT:
                  octet_next[l] = frame_sel_reg
                     ? 8'hff - 8'(l % 8) : 8'(l % 8);
               jlm_pkg::JLM_PAT_D215:
                  octet_next[l] = `JLM_D215_OCTET;
               jlm_pkg::JLM_PAT_NORMAL: begin
                  if (!used_lanes[l]) begin
                     // Extra lanes only need to toggle, not carry data
                     octet_next[l] = `JLM_D215_OCTET;
                  end else if (single) begin
                     octet_next[l] = sample_frame[2 * (l % 8) + l / 8];
                  end else begin
                     octet_next[l] = sample_frame[l];
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_octet <= '0;
         encoder_bypass <= 1'b0;
      end else begin
         lane_octet <= octet_next;
         encoder_bypass <= (pat == jlm_pkg::JLM_PAT_PRBS7)
            || (pat == jlm_pkg::JLM_PAT_PRBS15)
            || (pat == jlm_pkg::JLM_PAT_PRBS23);
      end
   end

endmodule

// >>> verif/jlm_lane_mapper_assertions.sv
// Checker for the lane mapper ports
module jlm_lane_mapper_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus writes, snooped
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   // Converter and link
   input wire logic power_down_pin,
   input wire jlm_pkg::jlm_frame_t sample_frame,
   input wire jlm_pkg::jlm_frame_t lane_octet,
   input wire logic [15:0] lane_enable,
   input wire logic encoder_bypass,
   input wire logic data_flushed
);
   // ****************************
   // Shadow state and properties
   // ****************************
   logic wr_ctrl_reg;
   logic [19:0] ctrl_reg;
   logic [7:0] low_reg;
   // Slave never stalls, so hready is not watched
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctrl_reg <= 1'b0;
         ctrl_reg <= 20'h00004;
      end else begin
         wr_ctrl_reg <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
         if (wr_ctrl_reg) ctrl_reg <= hwdata[19:0];
      end
   end
   // Saturates so a long outage cannot wrap to a small count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) low_reg <= 8'h00;
      else if (data_flushed) low_reg <= 8'h00;
      else if (low_reg != 8'hff) low_reg <= low_reg + 8'h01;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_pin_lanes_off: assert property (
      power_down_pin [*7] |-> lane_enable == 16'h0000)
      else $error("lanes enabled while pin high");
   a_stale_zero: assert property (
      !data_flushed |-> lane_octet == '0)
      else $error("octets sent before flush");
   a_flush_wait: assert property (
      $rose(data_flushed) |-> low_reg >= 8'd16)
      else $error("flush delay too short");
   a_low_lanes: assert property (
      lane_enable[7:0] inside {8'h00, 8'h03, 8'h0f, 8'hff} &&
      lane_enable[15:8] inside {8'h00, 8'h03, 8'h0f, 8'hff})
      else $error("lane enables not lowest first");
   a_chan_a_off: assert property (
      $past(ctrl_reg[16]) |-> lane_enable[7:0] == 8'h00)
      else $error("link a lanes on in channel power down");
   a_bypass_prbs: assert property (
      encoder_bypass == ($past(ctrl_reg[10:8]) inside {3'h1, 3'h2, 3'h3}))
      else $error("encoder bypass wrong");
   a_map_even_odd: assert property (
      $past(ctrl_reg) == 20'h00005 && $past(lane_enable) == 16'h0f0f &&
      $past(data_flushed) && data_flushed |->
      lane_octet[2] == $past(sample_frame[4]) &&
      lane_octet[9] == $past(sample_frame[3]))
      else $error("mode 5 sample placement wrong");
   a_d215_octet: assert property (
      $past(ctrl_reg[10:8], 2) == 3'h6 && $past(ctrl_reg[10:8]) == 3'h6 &&
      $past(lane_enable[0]) && $past(data_flushed) && data_flushed |->
      lane_octet[0] == 8'hb5)
      else $error("d21.5 octet wrong");
   c_flushed: cover property ($rose(data_flushed));
   c_bypass: cover property ($rose(encoder_bypass));
   c_pin_down: cover property (power_down_pin [*8]);
endmodule

bind jlm_lane_mapper jlm_lane_mapper_checker u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .power_down_pin(power_down_pin), .sample_frame(sample_frame),
   .lane_octet(lane_octet), .lane_enable(lane_enable),
   .encoder_bypass(encoder_bypass), .data_flushed(data_flushed));

// >>> verif/jlm_lane_mapper_test_patterns_bench.sv
// Self-checking bench for the lane mapper and test patterns
`include "jlm_defines.svh"
module jlm_lane_mapper_test_patterns_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic power_down_pin, ila_done, encoder_bypass, data_flushed, link_en;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [15:0] lane_enable, en;
   jlm_pkg::jlm_frame_t sample_frame, lane_octet, e;
   int bad_count, total_checks, cyc;
   // ***********************
   // Harness and scenarios
   // ***********************
   assign hready = hreadyout;
   jlm_lane_mapper dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .sample_frame(sample_frame),
      .power_down_pin(power_down_pin), .ila_done(ila_done),
      .lane_octet(lane_octet), .lane_enable(lane_enable),
      .encoder_bypass(encoder_bypass), .data_flushed(data_flushed));
   jlm_rx_model #(.ILA_CYC(8)) partner (.hclk(hclk), .hresetn(hresetn),
      .link_en(link_en), .data_flushed(data_flushed), .ila_done(ila_done));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // A new frame every clock so the one-cycle latency is really seen
   always @(posedge hclk) begin
      if (!hresetn) begin
         for (int i = 0; i < 16; i++) sample_frame[i] <= {4'(i), ~4'(i)};
      end else begin
         sample_frame <= {sample_frame[14:0], sample_frame[15]};
      end
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wait_flushed();
      for (int n = 0; n < 60 && data_flushed !== 1'b1; n++) @(posedge hclk);
      ticks(2);
   endtask
   // Expected octets and enables of a lane mode, normal data
   function automatic void set_exp(input logic [4:0] m);
      int n;
      logic dual;
      jlm_pkg::jlm_frame_t f;
      // Octets seen now were mapped from the frame one rotation back
      f = {sample_frame[0], sample_frame[15:1]};
      e = '0;
      dual = m == 5'd6 || m == 5'd7 || m == 5'd18;
      n = (m == 5'd4 || m == 5'd6) ? 2 : (m == 5'd5 || m == 5'd7) ? 4 : 8;
      en = {2{8'((1 << n) - 1)}};
      for (int k = 0; k < n; k++) begin
         e[k] = dual ? f[k] : f[2 * k];
         e[8 + k] = dual ? f[8 + k] : f[2 * k + 1];
      end
   endfunction
   task automatic t_regs();
      bus(1'b0, 8'h00, 32'h0);
      check(rdv, 32'h0000_0004);
      bus(1'b0, 8'h08, 32'h0);
      check({rdv, hresp}, {32'h0001_0303, 1'b0});
      bus(1'b0, 8'h04, 32'h0);
      check(rdv, 32'h0);
      bus(1'b1, 8'h1c, 32'hffff_ffff);
      bus(1'b0, 8'h1c, 32'h0);
      check(rdv, 32'h0);
      check(lane_enable, 16'h0303);
   endtask
   task automatic t_map();
      logic [4:0] m [6] = '{5'd4, 5'd5, 5'd6, 5'd7, 5'd17, 5'd18};
      foreach (m[i]) begin
         bus(1'b1, 8'h00, {27'h0, m[i]});
         ticks(5);
         set_exp(m[i]);
         check(lane_octet, e);
         check(lane_enable, en);
      end
      bus(1'b1, 8'h00, 32'h0000_0705);
      ticks(5);
      set_exp(5'd5);
      check(lane_octet, e);
   endtask
   task automatic t_power();
      bus(1'b1, 8'h00, 32'h0000_0005);
      power_down_pin <= 1'b1;
      ticks(9);
      check(lane_enable, 16'h0);
      power_down_pin <= 1'b0;
      ticks(10);
      check(data_flushed, 1'b0);
      wait_flushed();
      set_exp(5'd5);
      check(lane_octet, e);
      bus(1'b1, 8'h04, 32'h0000_0002);
      ticks(3);
      check(lane_enable, 16'h0);
      bus(1'b1, 8'h04, 32'h0000_0001);
      ticks(3);
      check(lane_enable, 16'h0f0f);
      bus(1'b1, 8'h00, 32'h0001_0005);
      ticks(3);
      check(lane_enable, 16'h0f00);
      bus(1'b1, 8'h00, 32'h0002_0005);
      ticks(3);
      check(lane_enable, 16'h000f);
      bus(1'b1, 8'h00, 32'h000c_0004);
      wait_flushed();
      check(lane_enable, 16'hffff);
      check(lane_octet[2], 8'hb5);
   endtask
   task automatic set_pat(input logic [2:0] p);
      link_en <= 1'b0;
      bus(1'b1, 8'h00, {21'h0, p, 8'h05});
      link_en <= 1'b1;
      ticks(14);
   endtask
   task automatic t_prbs(input logic [2:0] p, input int a, input int b);
      logic [63:0] bits;
      logic ok;
      set_pat(p);
      check(encoder_bypass, 1'b1);
      check(lane_enable, 16'h0f0f);
      check(lane_octet[0] == lane_octet[1], 1'b0);
      for (int j = 0; j < 8; j++) begin
         for (int i = 0; i < 8; i++) bits[8 * j + i] = lane_octet[0][7 - i];
         @(posedge hclk);
      end
      ok = 1'b1;
      for (int n = 23; n < 64; n++) begin
         if (bits[n] !== (bits[n - a] ^ bits[n - b])) ok = 1'b0;
      end
      check(ok, 1'b1);
   endtask
   task automatic t_ramp();
      logic [7:0] v;
      set_pat(`JLM_TPAT_RAMP);
      check(encoder_bypass, 1'b0);
      v = lane_octet[0];
      @(posedge hclk);
      check(lane_octet[0], v + 8'h01);
      check(lane_octet[11], v + 8'h01);
      for (int n = 0; n < 300 && lane_octet[0] !== 8'hff; n++) @(posedge hclk);
      @(posedge hclk);
      check(lane_octet[0], 8'h00);
   endtask
   task automatic t_fixed();
      logic ph;
      set_pat(`JLM_TPAT_SHORT);
      ph = lane_octet[0] == 8'hff;
      e = '0;
      repeat (2) begin
         for (int k = 0; k < 4; k++) begin
            e[k] = ph ? 8'hff - 8'(k) : 8'(k);
            e[8 + k] = e[k];
         end
         check(lane_octet, e);
         ph = ~ph;
         @(posedge hclk);
      end
      set_pat(`JLM_TPAT_D215);
      for (int k = 0; k < 4; k++) begin
         e[k] = `JLM_D215_OCTET;
         e[8 + k] = `JLM_D215_OCTET;
      end
      check(lane_octet, e);
   endtask
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      power_down_pin = 1'b0;
      link_en = 1'b1;
      ticks(3);
      hresetn <= 1'b1;
      wait_flushed();
      t_regs();
      t_map();
      t_power();
      t_prbs(`JLM_TPAT_PRBS7, 6, 7);
      t_prbs(`JLM_TPAT_PRBS15, 14, 15);
      t_prbs(`JLM_TPAT_PRBS23, 18, 23);
      t_ramp();
      t_fixed();
      finish_test();
   end
endmodule

// >>> verif/jlm_rx_model.sv
// Receiver model: alignment status after link bring-up
module jlm_rx_model #(
   parameter int ILA_CYC = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link control and flush status
   input wire logic link_en,
   input wire logic data_flushed,
   // Alignment status
   output logic ila_done
);
   // ***************
   // Link alignment
   // ***************
   logic [7:0] ila_reg;
   // Stale data is discarded: alignment restarts after any outage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ila_reg <= 8'h00;
      else if (!link_en || !data_flushed) ila_reg <= 8'h00;
      else if (ila_reg != 8'(ILA_CYC)) ila_reg <= ila_reg + 8'h01;
   end
   assign ila_done = ila_reg == 8'(ILA_CYC);
endmodule
